// ==== logic/edacr_defines.vh ====
// Constants for the protected on-chip RAM: register layout, bus codes and reset values.
`ifndef EDACR_DEFINES_VH
`define EDACR_DEFINES_VH

// ----------------------------------------------------------------------
// Configuration register
// ----------------------------------------------------------------------
`define EDACR_CFG_OFFSET 8'h00
`define EDACR_CNT_MSB 20
`define EDACR_CNT_LSB 13
`define EDACR_SIZE_MSB 12
`define EDACR_SIZE_LSB 10
`define EDACR_WBYP_BIT 9
`define EDACR_RCAP_BIT 8
`define EDACR_EN_BIT 7
`define EDACR_DIAG_MSB 6
`define EDACR_DIAG_LSB 0
`define EDACR_RSVD_W 11
`define EDACR_CNT_RESET 8'h00
`define EDACR_CNT_MAX 8'hff
`define EDACR_FLAG_RESET 1'b0

// ----------------------------------------------------------------------
// AHB codes
// ----------------------------------------------------------------------
`define EDACR_HRESP_OKAY 2'b00
`define EDACR_HRESP_ERROR 2'b01
`define EDACR_HSIZE_BYTE 3'b000
`define EDACR_HSIZE_HALF 3'b001

`endif

// ==== logic/edacr_store.v ====
// Word store with byte lanes plus a check-bit lane and a registered read port.
`timescale 1ns/1ps

`include "edacr_defines.vh"

module edacr_store #(
	parameter AW = 10
) (
	input wire clk,
	input wire re,
	input wire [AW-1:0] raddr,
	output wire [31:0] rdata,
	output reg [6:0] rcheck,
	input wire we,
	input wire [AW-1:0] waddr,
	input wire [3:0] be,
	input wire [31:0] wdata,
	input wire cwe,
	input wire [6:0] wcheck
);

	localparam DEPTH = 1 << AW;

	reg [6:0] check_mem [0:DEPTH-1];

	// A read of the word being written in the same cycle returns the new
	// contents, so a read right behind a zero-wait write never sees stale data.
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : lane
			reg [7:0] mem [0:DEPTH-1];
			reg [7:0] out_reg;
			wire hit;
			assign hit = we & be[g] & (waddr == raddr);
			always @(posedge clk)
			begin
				if (we & be[g])
					mem[waddr] <= wdata[8*g+7:8*g];
				if (re)
					out_reg <= hit ? wdata[8*g+7:8*g] : mem[raddr];
			end
			assign rdata[8*g+7:8*g] = out_reg;
		end
	endgenerate

	always @(posedge clk)
	begin
		if (we & cwe)
			check_mem[waddr] <= wcheck;
		if (re)
			rcheck <= (we & cwe & (waddr == raddr)) ? wcheck : check_mem[raddr];
	end

endmodule // edacr_store

// ==== logic/edacr_onchip_ram.v ====
// On-chip RAM with single-error correction, double-error detection and a config register.
`timescale 1ns/1ps

`include "edacr_defines.vh"

module edacr_onchip_ram #(
	parameter [2:0] RAM_KB_LOG2 = 3'd2
) (
	input wire clk,
	input wire resetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg hreadyout,
	output reg [1:0] hresp,
	output wire [31:0] hrdata,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire single_error_pulse
);

	localparam AW = 8 + RAM_KB_LOG2;
	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_OUT = 2'b01;
	localparam [1:0] ST_ERR1 = 2'b10;
	localparam [1:0] ST_ERR2 = 2'b11;

	// ------------------------------------------------------------------
	// Check-bit code
	// ------------------------------------------------------------------
	// Each data bit owns a distinct 6-bit column of weight two or more;
	// the seventh check bit is overall parity, which tells single from double.
	function [5:0] bit_code;
		input integer idx;
		integer v;
		integer n;
		integer k;
		integer w;
		reg [5:0] r;
		begin
			r = 6'h00;
			n = 0;
			for (v = 3; v < 64; v = v + 1)
			begin
				w = 0;
				for (k = 0; k < 6; k = k + 1)
					w = w + ((v >> k) & 1);
				if (w >= 2)
				begin
					if (n == idx)
						r = v[5:0];
					n = n + 1;
				end
			end
			bit_code = r;
		end
	endfunction

	function [6:0] ecc_encode;
		input [31:0] d;
		integer i;
		reg [5:0] c;
		begin
			c = 6'h00;
			for (i = 0; i < 32; i = i + 1)
				c = c ^ ({6{d[i]}} & bit_code(i));
			ecc_encode = {(^d) ^ (^c), c};
		end
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	reg dp_valid_reg;
	reg dp_write_reg;
	reg dp_sub_reg;
	reg dp_prot_reg;
	reg [AW-1:0] dp_addr_reg;
	reg [3:0] dp_be_reg;
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [31:0] hrdata_reg;
	reg protection_on_reg;
	reg read_checkbit_capture_reg;
	reg write_checkbit_bypass_reg;
	reg [6:0] diag_check_bits_reg;
	reg [7:0] single_error_count_reg;
	reg [7:0] single_error_count_next;
	reg single_error_pulse_reg;
	reg [31:0] prdata_reg;
	reg [3:0] be_dec;

	wire accept;
	wire need_dec;
	wire [31:0] mem_data;
	wire [6:0] mem_check;
	wire [6:0] rd_code;
	wire [5:0] syn;
	wire par;
	wire [31:0] fix;
	wire [31:0] corrected;
	wire [31:0] merged;
	wire data_hit;
	wire chk_only;
	wire single_err;
	wire double_err;
	wire mem_we;
	wire [3:0] mem_be;
	wire [31:0] mem_wdata;
	wire [6:0] mem_wcheck;
	wire cfg_wr;
	wire [31:0] cfg_word;

	assign accept = hsel & htrans[1] & hready;
	always @*
	begin
		case (hsize)
			`EDACR_HSIZE_BYTE: be_dec = 4'h1 << haddr[1:0];
			`EDACR_HSIZE_HALF: be_dec = haddr[1] ? 4'hc : 4'h3;
			default: be_dec = 4'hf;
		endcase
	end

	// ------------------------------------------------------------------
	// Address phase capture
	// ------------------------------------------------------------------
	// The protection mode is frozen per access so a register write that
	// lands mid-transfer cannot split one access across two behaviours.
	always @(posedge clk)
	begin
		if (!resetn)
		begin
			dp_valid_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_sub_reg <= 1'b0;
			dp_prot_reg <= 1'b0;
			dp_addr_reg <= {AW{1'b0}};
			dp_be_reg <= 4'h0;
		end
		else if (hready)
		begin
			dp_valid_reg <= accept;
			if (accept)
			begin
				dp_write_reg <= hwrite;
				dp_sub_reg <= (be_dec != 4'hf);
				dp_prot_reg <= protection_on_reg;
				dp_addr_reg <= haddr[AW+1:2];
				dp_be_reg <= be_dec;
			end
		end
	end

	edacr_store #(
		.AW(AW)
	) u_store (
		.clk(clk),
		.re(accept),
		.raddr(haddr[AW+1:2]),
		.rdata(mem_data),
		.rcheck(mem_check),
		.we(mem_we),
		.waddr(dp_addr_reg),
		.be(mem_be),
		.wdata(mem_wdata),
		.cwe(dp_prot_reg),
		.wcheck(mem_wcheck)
	);

	// ------------------------------------------------------------------
	// Decoder
	// ------------------------------------------------------------------
	assign rd_code = ecc_encode(mem_data);
	assign syn = rd_code[5:0] ^ mem_check[5:0];
	assign par = ^{mem_data, mem_check};
	genvar g;
	generate
		for (g = 0; g < 32; g = g + 1)
		begin : flip
			assign fix[g] = par & (syn == bit_code(g));
		end
	endgenerate
	assign corrected = mem_data ^ fix;
	assign data_hit = |fix;
	assign chk_only = ((syn & (syn - 6'd1)) == 6'h00);
	assign single_err = par & (data_hit | chk_only);
	assign double_err = (~par & (|syn)) | (par & ~(data_hit | chk_only));

	// Only protected reads and protected subword writes pay the decode cycle.
	assign need_dec = dp_valid_reg & dp_prot_reg & (~dp_write_reg | dp_sub_reg)
		& (state_reg == ST_IDLE);

	generate
		for (g = 0; g < 4; g = g + 1)
		begin : merge
			assign merged[8*g+7:8*g] = dp_be_reg[g] ? hwdata[8*g+7:8*g]
				: corrected[8*g+7:8*g];
		end
	endgenerate

	// ------------------------------------------------------------------
	// Store write path
	// ------------------------------------------------------------------
	// A subword write with protection goes out as a whole merged word in the
	// decode cycle; an uncorrectable word is left untouched.
	assign mem_we = dp_valid_reg & dp_write_reg & (state_reg == ST_IDLE)
		& ~(need_dec & double_err);
	assign mem_be = need_dec ? 4'hf : dp_be_reg;
	assign mem_wdata = need_dec ? merged : hwdata;
	assign mem_wcheck = write_checkbit_bypass_reg ? diag_check_bits_reg
		: ecc_encode(mem_wdata);

	// ------------------------------------------------------------------
	// Response sequencer
	// ------------------------------------------------------------------
	always @*
	begin
		hreadyout = 1'b1;
		hresp = `EDACR_HRESP_OKAY;
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (need_dec)
				begin
					hreadyout = 1'b0;
					state_next = double_err ? ST_ERR1 : ST_OUT;
				end
			end
			ST_OUT:
			begin
				state_next = ST_IDLE;
			end
			ST_ERR1:
			begin
				hreadyout = 1'b0;
				hresp = `EDACR_HRESP_ERROR;
				state_next = ST_ERR2;
			end
			ST_ERR2:
			begin
				hresp = `EDACR_HRESP_ERROR;
				state_next = ST_IDLE;
			end
			default:
			begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge clk)
	begin
		if (!resetn)
		begin
			state_reg <= ST_IDLE;
			hrdata_reg <= 32'h00000000;
		end
		else
		begin
			state_reg <= state_next;
			if (need_dec)
				hrdata_reg <= corrected;
		end
	end

	// Unprotected reads hand the store output straight to the bus.
	assign hrdata = (state_reg == ST_OUT) ? hrdata_reg
		: (dp_valid_reg & ~dp_write_reg & ~dp_prot_reg) ? mem_data
		: 32'h00000000;

	// ------------------------------------------------------------------
	// Configuration register
	// ------------------------------------------------------------------
	assign cfg_wr = psel & penable & pwrite & (paddr == `EDACR_CFG_OFFSET);

	always @*
	begin
		single_error_count_next = single_error_count_reg;
		if (cfg_wr)
			single_error_count_next = single_error_count_reg
				& ~pwdata[`EDACR_CNT_MSB:`EDACR_CNT_LSB];
		// A new error still counts in the cycle software clears the field.
		if (need_dec & single_err & (single_error_count_next != `EDACR_CNT_MAX))
			single_error_count_next = single_error_count_next + 8'h01;
	end

	always @(posedge clk)
	begin
		if (!resetn)
		begin
			protection_on_reg <= `EDACR_FLAG_RESET;
			read_checkbit_capture_reg <= `EDACR_FLAG_RESET;
			write_checkbit_bypass_reg <= `EDACR_FLAG_RESET;
			single_error_count_reg <= `EDACR_CNT_RESET;
			single_error_pulse_reg <= 1'b0;
		end
		else
		begin
			if (cfg_wr)
			begin
				protection_on_reg <= pwdata[`EDACR_EN_BIT];
				read_checkbit_capture_reg <= pwdata[`EDACR_RCAP_BIT];
				write_checkbit_bypass_reg <= pwdata[`EDACR_WBYP_BIT];
			end
			single_error_count_reg <= single_error_count_next;
			single_error_pulse_reg <= need_dec & single_err;
		end
	end

	// The test check bits are left out of reset on purpose so that a value
	// planted before a reset survives it for diagnosis.
	always @(posedge clk)
	begin
		if (need_dec & read_checkbit_capture_reg)
			diag_check_bits_reg <= mem_check;
		else if (cfg_wr)
			diag_check_bits_reg <= pwdata[`EDACR_DIAG_MSB:`EDACR_DIAG_LSB];
	end

	assign cfg_word = {{`EDACR_RSVD_W{1'b0}}, single_error_count_reg, RAM_KB_LOG2,
		write_checkbit_bypass_reg, read_checkbit_capture_reg, protection_on_reg,
		diag_check_bits_reg};

	always @(posedge clk)
	begin
		if (!resetn)
			prdata_reg <= 32'h00000000;
		else if (psel & ~penable)
			prdata_reg <= (paddr == `EDACR_CFG_OFFSET) ? cfg_word : 32'h00000000;
	end

	assign prdata = prdata_reg;
	assign single_error_pulse = single_error_pulse_reg;

endmodule // edacr_onchip_ram

// ==== verification/edacr_sva.sv ====
// Port assertions for the protected on-chip RAM.
`timescale 1ns/1ps
module edacr_sva #(
	parameter [2:0] RAM_KB_LOG2 = 3'd2
) (
	input logic clk,
	input logic resetn,
	input logic hsel,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic [2:0] hsize,
	input logic hready,
	input logic hreadyout,
	input logic [1:0] hresp,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic single_error_pulse
);
	// Mirror of the write bypass, read capture and protection bits.
	reg [2:0] cfg_reg;
	wire acc = hsel && htrans[1] && hready;
	wire sub = hsize == 3'b000 || hsize == 3'b001;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	always @(posedge clk)
	begin
		if (!resetn)
			cfg_reg <= 3'b000;
		else if (psel && penable && pwrite && paddr == 8'h00)
			cfg_reg <= pwdata[9:7];
	end
	word_write_a: assert property (acc && hwrite && !sub |=> hreadyout && hresp == 2'b00)
		else $error("Word write waited.");
	plain_access_a: assert property (acc && !cfg_reg[0] |=> hreadyout)
		else $error("Unprotected access waited.");
	protected_wait_a: assert property (acc && cfg_reg[0] && (!hwrite || sub) |=>
		!hreadyout ##1 (hreadyout || hresp == 2'b01))
		else $error("Protected access timing wrong.");
	error_pair_a: assert property (hresp == 2'b01 && !hreadyout |=> hresp == 2'b01 && hreadyout)
		else $error("Error response not two cycles.");
	error_lead_a: assert property ($rose(hresp == 2'b01) |-> !hreadyout)
		else $error("Error response began ready.");
	pulse_short_a: assert property (single_error_pulse |=> !single_error_pulse)
		else $error("Correction pulse too long.");
	pulse_quiet_a: assert property (single_error_pulse |-> hreadyout && hresp == 2'b00)
		else $error("Corrected access showed an error.");
	size_field_a: assert property (psel && penable && paddr == 8'h00 |->
		prdata[12:10] == RAM_KB_LOG2 && prdata[31:21] == 11'h000)
		else $error("Size or reserved field wrong.");
	flag_view_a: assert property (psel && penable && !pwrite && paddr == 8'h00 |->
		prdata[9:7] == cfg_reg)
		else $error("Control flags read back wrong.");
endmodule // edacr_sva
bind edacr_onchip_ram edacr_sva #(.RAM_KB_LOG2(RAM_KB_LOG2)) u_sva (.clk(clk), .resetn(resetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .single_error_pulse(single_error_pulse));

// ==== verification/edacr_ahb_master.sv ====
// Behavioural AHB master issuing one transfer at a time.
`timescale 1ns/1ps
module edacr_ahb_master (
	input logic clk,
	input logic hready,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
	end
	// Released write data is inverted so the slave cannot lean on a stale value.
	task xfer(input logic w, input logic [2:0] sz, input logic [31:0] a, input logic [31:0] d);
	begin
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		hsize <= sz;
		@(posedge clk);
		while (!hready) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= w ? d : ~d;
		@(posedge clk);
		while (!hready) @(posedge clk);
		hwdata <= ~hwdata;
	end
	endtask
endmodule // edacr_ahb_master

// ==== verification/edac_onchip_ram_tb.sv ====
// Self-checking bench for the protected on-chip RAM.
`timescale 1ns/1ps
module edac_onchip_ram_tb;
	reg clk, resetn, psel, penable, pwrite, dph, dpw;
	reg [7:0] paddr;
	reg [31:0] pwdata, d, a;
	reg [6:0] e;
	reg [33:0] q[$];
	integer seed, errors, compares, cyc, k, pulses;
	wire hsel, hwrite, hreadyout, single_error_pulse;
	wire [1:0] htrans, hresp;
	wire [2:0] hsize;
	wire [31:0] haddr, hwdata, hrdata, prdata;
	edacr_onchip_ram #(.RAM_KB_LOG2(3'd2)) u_dut (.clk(clk), .resetn(resetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.single_error_pulse(single_error_pulse));
	edacr_ahb_master u_mst (.clk(clk), .hready(hreadyout), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function [6:0] enc(input [31:0] v);
		integer i;
		reg [5:0] col;
		reg [6:0] c;
	begin
		c = 7'h00;
		col = 6'h03;
		for (i = 0; i < 32; i = i + 1)
		begin
			while ($countones(col) < 2) col = col + 6'h01;
			if (v[i]) c[5:0] = c[5:0] ^ col;
			col = col + 6'h01;
		end
		c[6] = ^{v, c[5:0]};
		enc = c;
	end
	endfunction
	function [33:0] cf(input [7:0] s, input [9:0] lo);
		cf = {13'h0000, s, 3'd2, lo};
	endfunction
	task chk(input [33:0] s, input [33:0] x);
	begin
		compares = compares + 1;
		if (s !== x)
		begin
			errors = errors + 1;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, x);
		end
	end
	endtask
	task close_out;
	begin
		if (errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	task apb(input w, input [7:0] ad, input [31:0] v);
	begin
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= v;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~v;
	end
	endtask
	task rdc(input [7:0] ad, input [33:0] x);
	begin
		q.push_back(x);
		apb(1'b0, ad, 32'h0);
	end
	endtask
	task wr(input [2:0] sz, input [31:0] ad, input [31:0] v);
	begin
		q.push_back(34'h0);
		u_mst.xfer(1'b1, sz, ad, v);
	end
	endtask
	task rd(input [31:0] ad, input [31:0] x);
	begin
		q.push_back({2'b00, x});
		u_mst.xfer(1'b0, 3'b010, ad, 32'h0);
	end
	endtask
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc > 6000)
		begin
			errors = errors + 1;
			close_out;
		end
		else
		begin
			if (resetn && dph && hreadyout)
				chk({hresp, (hresp == 2'b00 && !dpw) ? hrdata : 32'h0}, q.pop_front());
			if (psel && penable && !pwrite)
				chk({2'b00, prdata}, q.pop_front());
			if (single_error_pulse)
				pulses = pulses + 1;
			dph <= (hsel && htrans[1] && hreadyout) || (dph && !hreadyout);
			// Read data is only defined for reads; writes are checked on the response alone.
			if (hsel && htrans[1] && hreadyout)
				dpw <= hwrite;
		end
	end
	initial
	begin
		seed = 32'h84d0a187;
		errors = 0;
		compares = 0;
		cyc = 0;
		dph = 1'b0;
		dpw = 1'b0;
		pulses = 0;
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		apb(1'b1, 8'h00, 32'h0);
		rdc(8'h00, cf(8'h00, 10'h000));
		apb(1'b1, 8'h04, 32'hffffffff);
		rdc(8'h04, 34'h0);
		rdc(8'h00, cf(8'h00, 10'h000));
		a = 32'h100;
		d = $random(seed);
		wr(3'b010, a, d);
		rd(a, d);
		wr(3'b000, a + 2, {4{8'h5a}});
		d[23:16] = 8'h5a;
		rd(a, d);
		apb(1'b1, 8'h00, 32'h155);
		rd(a, d);
		rdc(8'h00, cf(8'h00, 10'h155));
		apb(1'b1, 8'h00, 32'h80);
		for (k = 0; k < 3; k = k + 1)
		begin
			a = $random(seed) & 32'hffc;
			d = $random(seed);
			wr(3'b010, a, d);
			rd(a, d);
			wr(3'b000, a + 1, {4{~d[7:0]}});
			d[15:8] = ~d[7:0];
			rd(a, d);
			wr(3'b001, a + 2, {2{~d[15:0]}});
			d[31:16] = ~d[15:0];
			rd(a, d);
		end
		e = enc(d ^ 32'h1);
		apb(1'b1, 8'h00, 32'h280 | e);
		wr(3'b010, a, d);
		apb(1'b1, 8'h00, 32'h180);
		rd(a, d ^ 32'h1);
		rdc(8'h00, cf(8'h01, 10'h180 | e));
		e = enc(d) ^ 7'h40;
		apb(1'b1, 8'h00, 32'h280 | e);
		wr(3'b010, a, d);
		apb(1'b1, 8'h00, 32'h80);
		rd(a, d);
		rdc(8'h00, cf(8'h02, 10'h080));
		e = enc(d) ^ 7'h03;
		apb(1'b1, 8'h00, 32'h280 | e);
		wr(3'b010, a, d);
		apb(1'b1, 8'h00, 32'h180);
		q.push_back({2'b01, 32'h0});
		u_mst.xfer(1'b0, 3'b010, a, 32'h0);
		q.push_back({2'b01, 32'h0});
		u_mst.xfer(1'b1, 3'b000, a, 32'h0);
		rdc(8'h00, cf(8'h02, 10'h180 | e));
		e = enc(d) ^ 7'h01;
		apb(1'b1, 8'h00, 32'h280 | e);
		wr(3'b010, a, d);
		apb(1'b1, 8'h00, 32'h80);
		repeat (260) rd(a, d);
		rdc(8'h00, cf(8'hff, 10'h080));
		apb(1'b1, 8'h00, 32'h1e080);
		rdc(8'h00, cf(8'hf0, 10'h080));
		repeat (2) @(posedge clk);
		chk(pulses, 262);
		close_out;
	end
endmodule // edac_onchip_ram_tb
